// file: src/ebc_pkg.sv
// Package of constants and types for the exception boundary control unit.
// Contract
// RULE_01 - Vector number indexes handler descriptor table.
// RULE_02 - Table lookup used in every mode.
// RULE_03 - Stop program, save return instruction pointer.
// RULE_04 - Masked external interrupt stays pending.
// RULE_05 - Masked float exception gets default handling.
// RULE_06 - Precise boundary is oldest uncompleted instruction.
// RULE_07 - Precise event saves pointer to boundary.
// RULE_08 - Imprecise event may be at any instruction.
// RULE_09 - Boundary before: cause never updates state.
// RULE_10 - Boundary after: cause and older complete.
// RULE_11 - Task switch may leave registers updated.
// RULE_12 - Task switch disabled in long mode.
// RULE_13 - Fault discards state, points at itself.
// RULE_14 - Trap completes, points at next instruction.
// RULE_15 - Abort is imprecise, not restartable.
// RULE_16 - External interrupts are asynchronous bus signals.
// RULE_17 - Interrupt instruction raises synchronous event.
// RULE_18 - Single step and breakpoint raise exceptions.
// RULE_19 - Maskable interrupt needs interrupt enable flag.
// RULE_20 - Nonmaskable blocks further until interrupt return.
// RULE_21 - 256 vectors, lowest 32 reserved.
// RULE_22 - Stack selector load shadows one instruction.
// RULE_23 - One record per delivered event.
// RULE_24 - External requests sampled at instruction boundaries.
package ebc_pkg;
	// Vector space size and the reserved range at its bottom.
	localparam int VEC_COUNT = 256;
	localparam int VEC_RESERVED = 32;
	localparam int VEC_W = 8;
	localparam int IP_W = 64;
	// Fixed vectors; the unit itself uses VEC_DEBUG and VEC_NMI, and VEC_TASK_SWITCH is not used.
	localparam logic [7:0] VEC_DEBUG = 8'h01;
	localparam logic [7:0] VEC_NMI = 8'h02;
	localparam logic [7:0] VEC_TASK_SWITCH = 8'h0a;
	// Event class carried in each delivery record.
	typedef enum logic [1:0] {
		EBC_CLASS_FAULT = 2'h0,
		EBC_CLASS_TRAP = 2'h1,
		EBC_CLASS_ABORT = 2'h2,
		EBC_CLASS_INTR = 2'h3
	} ebc_class_t;
	// Operating mode of the core.
	typedef enum logic [1:0] {
		EBC_MODE_REAL = 2'h0,
		EBC_MODE_PROT = 2'h1,
		EBC_MODE_LONG = 2'h2
	} ebc_mode_t;
	// Reset value of the nonmaskable block and shadow state.
	localparam logic NMI_BLOCK_RST = 1'b0;
	localparam logic SHADOW_RST = 1'b0;
endpackage

// file: src/ebc_unit.sv
// Exception boundary control: classifies events and issues delivery records.
`timescale 1ns/100ps
module ebc_unit
	import ebc_pkg::*;
#(
	parameter int DESC_W = 4
) (
	input wire logic clk,
	input wire logic rst,
	// Retiring instruction: valid pulse with its address and length-next address.
	input wire logic retire_valid,
	input wire logic [IP_W-1:0] retire_ip,
	input wire logic [IP_W-1:0] retire_next_ip,
	input wire logic retire_is_stack_selector_load,
	input wire logic retire_is_interrupt_return,
	input wire logic retire_is_task_switch,
	// Synchronous fault reported against the retiring instruction.
	input wire logic fault_valid,
	input wire logic [VEC_W-1:0] fault_vector,
	// Synchronous trap reported against the retiring instruction.
	input wire logic trap_valid,
	input wire logic [VEC_W-1:0] trap_vector,
	// Software interrupt instruction retiring with its vector.
	input wire logic soft_int_valid,
	input wire logic [VEC_W-1:0] soft_int_vector,
	// Single step and address breakpoint conditions on the retiring instruction.
	input wire logic single_step,
	input wire logic breakpoint_hit,
	// Floating-point exception condition and its mask.
	input wire logic fp_exc_valid,
	input wire logic fp_exc_masked,
	input wire logic [VEC_W-1:0] fp_exc_vector,
	// Abort condition, not tied to any instruction.
	input wire logic abort_valid,
	input wire logic [VEC_W-1:0] abort_vector,
	// External interrupt signalling from system logic.
	input wire logic ext_int_req,
	input wire logic [VEC_W-1:0] ext_int_vector,
	input wire logic nmi_req,
	// Core state.
	input wire logic interrupt_enable_flag,
	input wire ebc_mode_t mode,
	input wire logic [IP_W-1:0] handler_descriptor_table,
	// Delivery record to the control-transfer path.
	output logic deliver_valid,
	output logic [VEC_W-1:0] deliver_vector,
	output ebc_class_t deliver_class,
	output logic [IP_W-1:0] saved_instruction_pointer,
	output logic [IP_W-1:0] deliver_desc_addr,
	output logic deliver_restartable,
	output logic commit_ok,
	output logic flush,
	output logic fp_default_apply,
	output logic task_switch_enable,
	output logic ext_int_pending,
	output logic nmi_pending,
	output logic nmi_blocked
);
	// Held interrupt state.
	logic ext_pend, next_ext_pend;
	logic [VEC_W-1:0] ext_vec, next_ext_vec;
	logic nmi_pend, next_nmi_pend;
	logic nmi_block, next_nmi_block;
	logic shadow, next_shadow;
	// Registered delivery record.
	logic dv, next_dv;
	logic [VEC_W-1:0] dvec, next_dvec;
	ebc_class_t dcls, next_dcls;
	logic [IP_W-1:0] dip, next_dip;
	logic drst, next_drst;
	logic fpd, next_fpd;
	// Combinational selections.
	logic take_fault, take_trap, take_nmi, take_ext, take_abort, sync_trap;
	logic [VEC_W-1:0] trap_vec_sel;

	// Descriptor address is vector times entry size plus table base.
	function automatic logic [IP_W-1:0] desc_addr(input logic [IP_W-1:0] base,
			input logic [VEC_W-1:0] vec);
		desc_addr = base + ({{(IP_W-VEC_W){1'b0}}, vec} << DESC_W);
	endfunction

	// Pending vector wins over a freshly arriving one.
	function automatic logic [VEC_W-1:0] next_ext_vec_sel(input logic pend,
			input logic [VEC_W-1:0] held, input logic [VEC_W-1:0] fresh);
		next_ext_vec_sel = pend ? held : fresh;
	endfunction

	// Event selection: abort first, then fault, then trap, then interrupts.
	always_comb begin
		// An abort needs no retiring instruction, so it can cut in at any cycle.
		take_abort = abort_valid; // see RULE_08
		take_fault = retire_valid && !take_abort && fault_valid; // see RULE_09
		// Software interrupt, debug and unmasked float conditions retire as traps.
		sync_trap = trap_valid || soft_int_valid || single_step || breakpoint_hit
			|| (fp_exc_valid && !fp_exc_masked); // see RULE_17
		trap_vec_sel = trap_vector;
		if (soft_int_valid) begin
			trap_vec_sel = soft_int_vector; // see RULE_17
		end else if (single_step || breakpoint_hit) begin
			trap_vec_sel = VEC_DEBUG; // see RULE_18
		end else if (fp_exc_valid && !fp_exc_masked) begin
			trap_vec_sel = fp_exc_vector;
		end else if (trap_valid) begin
			trap_vec_sel = trap_vector;
		end
		// Debug traps are held off in the stack selector shadow.
		take_trap = retire_valid && !take_abort && !fault_valid && sync_trap
			&& !(shadow && (single_step || breakpoint_hit) && !trap_valid
			&& !soft_int_valid); // see RULE_22
		// Interrupts are only taken at a clean retirement boundary.
		take_nmi = retire_valid && !take_abort && !fault_valid && !take_trap
			&& (nmi_pend || nmi_req) && !nmi_block && !shadow; // see RULE_24
		take_ext = retire_valid && !take_abort && !fault_valid && !take_trap && !take_nmi
			&& (ext_pend || ext_int_req) && interrupt_enable_flag && !shadow; // see RULE_19
	end

	// Next state of the held interrupts, shadow and delivery record.
	always_comb begin
		// Asynchronous requests are latched whenever they arrive.
		next_ext_pend = (ext_pend || ext_int_req) && !take_ext; // see RULE_04
		next_ext_vec = ext_int_req && !ext_pend ? ext_int_vector : ext_vec; // see RULE_16
		next_nmi_pend = (nmi_pend || nmi_req) && !take_nmi;
		// Set wins over the interrupt-return clear in the same cycle.
		next_nmi_block = take_nmi || (nmi_block && !(retire_valid && !fault_valid
			&& retire_is_interrupt_return)); // see RULE_20
		next_shadow = shadow;
		if (retire_valid && !fault_valid) begin
			next_shadow = retire_is_stack_selector_load && !shadow; // see RULE_22
		end
		next_dv = take_abort || take_fault || take_trap || take_nmi || take_ext; // see RULE_23
		// Record fields keep their values between deliveries so a slow reader still sees them.
		next_dvec = dvec;
		next_dcls = dcls;
		next_dip = dip;
		next_drst = drst;
		if (take_abort) begin
			next_dvec = abort_vector;
			next_dcls = EBC_CLASS_ABORT; // see RULE_15
			next_dip = retire_ip;
			next_drst = 1'b0;
		end else if (take_fault) begin
			next_dvec = fault_vector;
			next_dcls = EBC_CLASS_FAULT;
			next_dip = retire_ip; // see RULE_13
			next_drst = 1'b1;
		end else if (take_trap) begin
			next_dvec = trap_vec_sel;
			next_dcls = EBC_CLASS_TRAP;
			next_dip = retire_next_ip; // see RULE_14
			next_drst = 1'b1;
		end else if (take_nmi || take_ext) begin
			next_dvec = take_nmi ? VEC_NMI : next_ext_vec_sel(ext_pend, ext_vec, ext_int_vector);
			next_dcls = EBC_CLASS_INTR;
			next_dip = retire_next_ip; // see RULE_07
			next_drst = 1'b1;
		end
		// Masked float conditions are resolved by default handling.
		next_fpd = fp_exc_valid && fp_exc_masked; // see RULE_05
	end

	// Registers of the whole unit.
	// Reset values are constants only, so reset never hangs on a live input.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ext_pend <= 1'b0;
			ext_vec <= 8'h00;
			nmi_pend <= 1'b0;
			nmi_block <= NMI_BLOCK_RST;
			shadow <= SHADOW_RST;
			dv <= 1'b0;
			dvec <= 8'h00;
			dcls <= EBC_CLASS_FAULT;
			dip <= 64'h0;
			drst <= 1'b0;
			fpd <= 1'b0;
		end else begin
			ext_pend <= next_ext_pend;
			ext_vec <= next_ext_vec;
			nmi_pend <= next_nmi_pend;
			nmi_block <= next_nmi_block;
			shadow <= next_shadow;
			dv <= next_dv;
			dvec <= next_dvec;
			dcls <= next_dcls;
			dip <= next_dip;
			drst <= next_drst;
			fpd <= next_fpd;
		end
	end

	// A faulting or aborted instruction never commits; older ones already did.
	// A task switch in long mode has no hardware behind it, so it never commits either.
	assign commit_ok = retire_valid && !fault_valid && !abort_valid
		&& !(retire_is_task_switch && !task_switch_enable); // see RULE_10 RULE_12
	// Younger work is squashed as control passes to the handler.
	assign flush = next_dv; // see RULE_03
	// Task switch hardware exists outside long mode only.
	assign task_switch_enable = (mode != EBC_MODE_LONG); // see RULE_12
	// A task switch trap may leave switched registers updated; nothing restores them.
	assign deliver_valid = dv; // see RULE_11
	assign deliver_vector = dvec;
	assign deliver_class = dcls;
	assign saved_instruction_pointer = dip; // see RULE_06
	// Same table lookup in every mode.
	assign deliver_desc_addr = desc_addr(handler_descriptor_table, dvec); // see RULE_01 RULE_02
	assign deliver_restartable = drst;
	assign fp_default_apply = fpd;
	assign ext_int_pending = ext_pend;
	assign nmi_pending = nmi_pend;
	assign nmi_blocked = nmi_block;

	// The vector field spans exactly the full vector space.
	a_vec_space: assert property (@(posedge clk) disable iff (rst) // see RULE_21
		(2 ** VEC_W == VEC_COUNT) && (VEC_RESERVED < VEC_COUNT))
		else $error("vector space size wrong");
	a_fault_ip: assert property (@(posedge clk) disable iff (rst) // see RULE_13
		take_fault |=> deliver_valid && deliver_class == EBC_CLASS_FAULT
		&& saved_instruction_pointer == $past(retire_ip))
		else $error("fault saved pointer wrong");
	a_trap_ip: assert property (@(posedge clk) disable iff (rst) // see RULE_14
		take_trap |=> deliver_class == EBC_CLASS_TRAP
		&& saved_instruction_pointer == $past(retire_next_ip))
		else $error("trap saved pointer wrong");
	a_fault_nocommit: assert property (@(posedge clk) disable iff (rst) // see RULE_09
		fault_valid |-> !commit_ok)
		else $error("faulting instruction committed");
	a_ext_pending: assert property (@(posedge clk) disable iff (rst) // see RULE_04
		ext_int_req && !take_ext |=> ext_int_pending)
		else $error("external interrupt lost");
	a_if_gate: assert property (@(posedge clk) disable iff (rst) // see RULE_19
		take_ext |-> interrupt_enable_flag)
		else $error("interrupt taken while disabled");
	a_nmi_block: assert property (@(posedge clk) disable iff (rst) // see RULE_20
		take_nmi |=> nmi_blocked)
		else $error("nmi did not block");
	a_shadow_hold: assert property (@(posedge clk) disable iff (rst) // see RULE_22
		shadow |-> !take_ext && !take_nmi)
		else $error("interrupt inside stack shadow");
	a_abort_class: assert property (@(posedge clk) disable iff (rst) // see RULE_15
		abort_valid |=> deliver_class == EBC_CLASS_ABORT && !deliver_restartable)
		else $error("abort not imprecise");
	a_fp_masked: assert property (@(posedge clk) disable iff (rst) // see RULE_05
		fp_exc_valid && fp_exc_masked |=> fp_default_apply)
		else $error("masked float not defaulted");
	a_long_ts: assert property (@(posedge clk) disable iff (rst) // see RULE_12
		mode == EBC_MODE_LONG |-> !task_switch_enable)
		else $error("task switch in long mode");

	// Further guards on the delivery record and the held interrupt state.
	// Interrupt return lifts the nonmaskable block unless a new one is taken at once.
	a_nmi_release: assert property (@(posedge clk) disable iff (rst) // see RULE_20
		retire_valid && !fault_valid && retire_is_interrupt_return && !take_nmi
		|=> !nmi_blocked)
		else $error("nmi block not released");
	// Every taken event shows up as exactly one record on the next cycle.
	a_flush_record: assert property (@(posedge clk) disable iff (rst) // see RULE_23
		flush |=> deliver_valid)
		else $error("taken event gave no record");
	a_quiet_record: assert property (@(posedge clk) disable iff (rst) // see RULE_23
		!flush |=> !deliver_valid)
		else $error("record without a taken event");
	// Interrupts wait for a retiring instruction so that a boundary exists.
	a_int_boundary: assert property (@(posedge clk) disable iff (rst) // see RULE_24
		!retire_valid |-> !take_ext && !take_nmi)
		else $error("interrupt taken off a boundary");
	// A masked float condition alone never starts a trap.
	a_fp_no_trap: assert property (@(posedge clk) disable iff (rst) // see RULE_05
		fp_exc_valid && fp_exc_masked && !trap_valid && !soft_int_valid
		&& !single_step && !breakpoint_hit |-> !take_trap)
		else $error("masked float raised a trap");
	// A stack selector load outside the shadow arms it for one instruction.
	a_shadow_arm: assert property (@(posedge clk) disable iff (rst) // see RULE_22
		retire_valid && !fault_valid && retire_is_stack_selector_load && !shadow
		|=> shadow)
		else $error("stack shadow not armed");
	// A held external request is delivered with the vector it first brought.
	a_ext_vector: assert property (@(posedge clk) disable iff (rst) // see RULE_04
		take_ext && ext_pend |=> deliver_vector == $past(ext_vec))
		else $error("held vector lost");
	// An abort pre-empts every other event in its cycle.
	a_abort_first: assert property (@(posedge clk) disable iff (rst) // see RULE_08
		abort_valid |-> !take_fault && !take_trap && !take_ext && !take_nmi)
		else $error("event taken beside an abort");
	// A task switch in long mode must never commit its register updates.
	a_ts_commit: assert property (@(posedge clk) disable iff (rst) // see RULE_12
		retire_valid && retire_is_task_switch && mode == EBC_MODE_LONG |-> !commit_ok)
		else $error("task switch committed in long mode");
	// A trapping instruction completes before its record goes out, except a task switch in long mode.
	a_trap_commit: assert property (@(posedge clk) disable iff (rst) // see RULE_10
		take_trap && !retire_is_task_switch |-> commit_ok)
		else $error("trapping instruction not committed");
	// Interrupts resume after the retired instruction and stay restartable.
	a_int_record: assert property (@(posedge clk) disable iff (rst) // see RULE_07
		take_ext || take_nmi |=> deliver_class == EBC_CLASS_INTR && deliver_restartable
		&& saved_instruction_pointer == $past(retire_next_ip))
		else $error("interrupt record wrong");
	// An interrupt instruction delivers its own vector.
	a_soft_vec: assert property (@(posedge clk) disable iff (rst) // see RULE_17
		take_trap && soft_int_valid |=> deliver_vector == $past(soft_int_vector))
		else $error("software interrupt vector wrong");
	// Single step and breakpoint share the debug vector.
	a_debug_vec: assert property (@(posedge clk) disable iff (rst) // see RULE_18
		take_trap && !soft_int_valid && (single_step || breakpoint_hit)
		|=> deliver_vector == VEC_DEBUG)
		else $error("debug trap vector wrong");
endmodule

// file: test/ebc_pipe_model.sv
// Model of the retirement pipeline and the external interrupt signalling.
`timescale 1ns/100ps
module ebc_pipe_model
	import ebc_pkg::*;
(
	output logic retire_valid,
	output logic [IP_W-1:0] retire_ip,
	output logic [IP_W-1:0] retire_next_ip,
	output logic ext_int_req,
	output logic [VEC_W-1:0] ext_int_vector,
	output logic nmi_req
);
	// Start quiet so the unit sees no request during reset.
	initial begin
		retire_valid = 1'b0;
		retire_ip = '0;
		retire_next_ip = '0;
		ext_int_req = 1'b0;
		ext_int_vector = '0;
		nmi_req = 1'b0;
	end
	// Idle lines show the inverse of their last value, so stale data never looks valid.
	task automatic issue(input logic r, input logic [IP_W-1:0] ip, input logic e,
		input logic [VEC_W-1:0] v, input logic n);
		retire_valid = r;
		retire_ip = r ? ip : ~retire_ip;
		retire_next_ip = r ? ip + 64'h4 : ~retire_next_ip;
		ext_int_req = e;
		ext_int_vector = e ? v : ~ext_int_vector;
		nmi_req = n;
	endtask
endmodule

// file: test/exception_boundary_control_tb.sv
// Self-checking bench for the exception boundary control unit.
`timescale 1ns/100ps
module exception_boundary_control_tb
	import ebc_pkg::*;
;
	logic clk, rst, retire_valid, ssl, int_ret, tsw, fault_valid, trap_valid, soft_int_valid;
	logic single_step, breakpoint_hit, fp_exc_valid, fp_exc_masked, abort_valid;
	logic ext_int_req, nmi_req, interrupt_enable_flag, deliver_valid, deliver_restartable;
	logic commit_ok, flush, fp_default_apply, task_switch_enable;
	logic ext_int_pending, nmi_pending, nmi_blocked;
	logic [VEC_W-1:0] fault_vector, trap_vector, soft_int_vector, fp_exc_vector;
	logic [VEC_W-1:0] abort_vector, ext_int_vector, deliver_vector, v, hit;
	logic [IP_W-1:0] retire_ip, retire_next_ip, base, saved_instruction_pointer;
	logic [IP_W-1:0] deliver_desc_addr, ip;
	ebc_mode_t mode;
	ebc_class_t deliver_class;
	int bad_count, check_count;
	// The far side drives retirement and interrupt lines.
	ebc_pipe_model u_pipe (.retire_valid(retire_valid), .retire_ip(retire_ip),
		.retire_next_ip(retire_next_ip), .ext_int_req(ext_int_req),
		.ext_int_vector(ext_int_vector), .nmi_req(nmi_req));
	ebc_unit #(.DESC_W(4)) u_dut (.clk(clk), .rst(rst), .retire_valid(retire_valid),
		.retire_ip(retire_ip), .retire_next_ip(retire_next_ip),
		.retire_is_stack_selector_load(ssl), .retire_is_interrupt_return(int_ret),
		.retire_is_task_switch(tsw), .fault_valid(fault_valid), .fault_vector(fault_vector),
		.trap_valid(trap_valid), .trap_vector(trap_vector), .soft_int_valid(soft_int_valid),
		.soft_int_vector(soft_int_vector), .single_step(single_step),
		.breakpoint_hit(breakpoint_hit), .fp_exc_valid(fp_exc_valid),
		.fp_exc_masked(fp_exc_masked), .fp_exc_vector(fp_exc_vector),
		.abort_valid(abort_valid), .abort_vector(abort_vector), .ext_int_req(ext_int_req),
		.ext_int_vector(ext_int_vector), .nmi_req(nmi_req),
		.interrupt_enable_flag(interrupt_enable_flag), .mode(mode),
		.handler_descriptor_table(base), .deliver_valid(deliver_valid),
		.deliver_vector(deliver_vector), .deliver_class(deliver_class),
		.saved_instruction_pointer(saved_instruction_pointer),
		.deliver_desc_addr(deliver_desc_addr), .deliver_restartable(deliver_restartable),
		.commit_ok(commit_ok), .flush(flush), .fp_default_apply(fp_default_apply),
		.task_switch_enable(task_switch_enable), .ext_int_pending(ext_int_pending),
		.nmi_pending(nmi_pending), .nmi_blocked(nmi_blocked));
	// Core clock of 20 ns.
	always #10 clk = ~clk;
	// Compares one value and counts it.
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string nm);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Table entries are 16 bytes wide, so the vector is shifted by four.
	function automatic logic [63:0] exp_desc(input logic [7:0] vec);
		return base + ({56'h0, vec} << 4);
	endfunction
	// Prints the verdict and ends the run.
	task automatic stop_test();
		if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Clears every event at a falling edge and lets the far side present one cycle.
	task automatic cyc(input logic r, input logic e, input logic n);
		@(negedge clk);
		{fault_valid, trap_valid, soft_int_valid, single_step, breakpoint_hit} = '0;
		{fp_exc_valid, fp_exc_masked, abort_valid, ssl, int_ret, tsw} = '0;
		ip = ip + 64'h10;
		u_pipe.issue(r, ip, e, v, n);
	endtask
	// Checks the record 2 ns after the taking edge that registers it.
	task automatic rec(input ebc_class_t c, input logic [7:0] vec, input logic rs);
		@(posedge clk);
		#2;
		chk(deliver_valid, 1'b1, "valid");
		chk(deliver_class, c, "class");
		chk(deliver_vector, vec, "vector");
		chk(deliver_desc_addr, exp_desc(vec), "desc");
		chk(deliver_restartable, rs, "restart");
		if (c == EBC_CLASS_FAULT) chk(saved_instruction_pointer, ip, "sip");
		if (c > EBC_CLASS_ABORT || c == EBC_CLASS_TRAP)
			chk(saved_instruction_pointer, ip + 64'h4, "sip");
	endtask
	// Watchdog cuts a hang short.
	initial begin
		#200000;
		bad_count++;
		stop_test();
	end
	initial begin
		{clk, tsw, fault_valid, trap_valid, soft_int_valid, single_step} = '0;
		{breakpoint_hit, fp_exc_valid, fp_exc_masked, abort_valid, ssl, int_ret} = '0;
		{fault_vector, trap_vector, soft_int_vector, fp_exc_vector, abort_vector} = '0;
		{interrupt_enable_flag, ip, v, hit} = '0;
		rst = 1'b1;
		mode = EBC_MODE_REAL;
		void'($urandom(41));
		base = {$urandom, $urandom};
		repeat (12) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		// Faults with random vectors in each mode.
		for (int m = 0; m < 3; m++) begin
			mode = ebc_mode_t'(m);
			v = 8'($urandom_range(0, 255));
			cyc(1'b1, 1'b0, 1'b0);
			fault_valid = 1'b1;
			fault_vector = v;
			#2 chk({flush, commit_ok}, 2'b10, "flush");
			chk(task_switch_enable, m != 2, "tsw");
			rec(EBC_CLASS_FAULT, v, 1'b1);
		end
		// A task switch commits outside long mode only.
		cyc(1'b1, 1'b0, 1'b0);
		tsw = 1'b1;
		#2 chk(commit_ok, 1'b0, "tslong");
		mode = EBC_MODE_PROT;
		#2 chk(commit_ok, 1'b1, "tsprot");
		// Trap, interrupt instruction, unmasked float, then both debug sources.
		for (int k = 0; k < 5; k++) begin
			v = 8'($urandom_range(32, 255));
			cyc(1'b1, 1'b0, 1'b0);
			{trap_valid, soft_int_valid, fp_exc_valid} = 3'b100 >> k;
			{trap_vector, soft_int_vector, fp_exc_vector} = {v, v, v};
			single_step = k == 3;
			breakpoint_hit = k == 4;
			#2 chk(commit_ok, 1'b1, "commit");
			rec(EBC_CLASS_TRAP, k > 2 ? VEC_DEBUG : v, 1'b1);
		end
		// Masked float takes the default path.
		cyc(1'b1, 1'b0, 1'b0);
		{fp_exc_valid, fp_exc_masked} = 2'b11;
		@(posedge clk) #2 chk({deliver_valid, fp_default_apply}, 2'b01, "fpdef");
		// Abort with no retiring instruction.
		cyc(1'b0, 1'b0, 1'b0);
		{abort_valid, abort_vector} = {1'b1, 8'h08};
		rec(EBC_CLASS_ABORT, 8'h08, 1'b0);
		// Masked external request is held, then needs a boundary.
		v = 8'($urandom_range(32, 255));
		cyc(1'b1, 1'b1, 1'b0);
		@(posedge clk) #2 chk({deliver_valid, ext_int_pending}, 2'b01, "pend");
		cyc(1'b0, 1'b0, 1'b0);
		interrupt_enable_flag = 1'b1;
		@(posedge clk) #2 chk(deliver_valid, 1'b0, "noret");
		cyc(1'b1, 1'b0, 1'b0);
		rec(EBC_CLASS_INTR, v, 1'b1);
		// Stack selector load shadows the following instruction.
		cyc(1'b1, 1'b0, 1'b0);
		ssl = 1'b1;
		cyc(1'b1, 1'b1, 1'b0);
		@(posedge clk) #2 chk(deliver_valid, 1'b0, "shadow");
		cyc(1'b1, 1'b0, 1'b0);
		rec(EBC_CLASS_INTR, v, 1'b1);
		// Nonmaskable: taken, blocks the next, released by interrupt return.
		interrupt_enable_flag = 1'b0;
		cyc(1'b1, 1'b0, 1'b1);
		rec(EBC_CLASS_INTR, VEC_NMI, 1'b1);
		cyc(1'b1, 1'b0, 1'b1);
		@(posedge clk) #2 chk({deliver_valid, nmi_blocked, nmi_pending}, 3'b011, "nmi");
		for (int k = 0; k < 4; k++) begin
			cyc(1'b1, 1'b0, 1'b0);
			int_ret = k == 0;
			@(posedge clk) #2 if (deliver_valid === 1'b1) hit = deliver_vector;
		end
		chk(hit, VEC_NMI, "nmiret");
		// A reset in mid-run clears the block, so the next nonmaskable is taken at once.
		@(negedge clk) rst = 1'b1;
		@(negedge clk) rst = 1'b0;
		#2 chk({nmi_blocked, nmi_pending, ext_int_pending}, 3'b000, "reset");
		cyc(1'b1, 1'b0, 1'b1);
		rec(EBC_CLASS_INTR, VEC_NMI, 1'b1);
		cyc(1'b0, 1'b0, 1'b0);
		stop_test();
	end
endmodule
